// ### shared/df_pkg.sv
// constants and types shared by both ends of the double frequency link
// assumes a 10 MHz core clock on both ends
package df_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int PULSE_NS = 100;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BYTE_NS = 3200;
    localparam int BYTE_CYC = BYTE_NS / CLK_NS;
    localparam int CELL_CYC = BYTE_CYC / 8;
    localparam int MARK_NS = 40000;
    localparam int MARK_CYC = MARK_NS / CLK_NS;
    localparam int REV_FAST_US = 25000;
    localparam int REV_SLOW_US = 40000;
    localparam int REV_FAST_CYC = REV_FAST_US * 1000 / CLK_NS;
    localparam int REV_SLOW_CYC = REV_SLOW_US * 1000 / CLK_NS;

    // ---------------------------------------------------------------
    // sector format
    // ---------------------------------------------------------------
    localparam int RPM = 2400;
    localparam int SECTORS = 8;
    localparam int SLOT_ERR_US = 14;
    localparam int TOL_US = 200;
    localparam int USABLE_US =
        (998 * 60000) / (RPM * SECTORS) - SLOT_ERR_US;
    localparam int DATA_BYTES =
        (USABLE_US - TOL_US) * 1000 / BYTE_NS;
    localparam int PRE_BYTES = 6;
    localparam int PRE_LONG_BYTES = 16;
    localparam int SYNC_BYTES = 2;
    localparam int HDR_BYTES = 2;
    localparam int CHK_BYTES = 2;
    localparam int GAP_BYTES = 1;
    localparam int POST_BYTES = 2;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] SYNC_BYTE = 8'h03;
    localparam logic [15:0] SYNC_WORD = 16'h0303;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 4;

    typedef enum logic [1:0] {OP_FORMAT, OP_WRITE, OP_READ} op_t;

endpackage

// ### shared/df_link_if.sv
// the pins between disk controller and drive
// assumes both ends sample these through their own synchronisers
`timescale 1ns/1ps
interface df_link_if;
    logic wr_pulse;
    logic write_gate;
    logic erase_gate;
    logic read_gate;
    logic read_clock;
    logic read_data;
    logic sector_mark_n;
    logic index_mark_n;

    modport ctrl (
        output wr_pulse, write_gate, erase_gate, read_gate,
        input read_clock, read_data, sector_mark_n, index_mark_n
    );
    modport drive (
        input wr_pulse, write_gate, erase_gate, read_gate,
        output read_clock, read_data, sector_mark_n, index_mark_n
    );
endinterface

// ### hdl/drive_end.sv
// drive end: sector and index marks, write flux, read clock/data split
// assumes the controller keeps the field layout and gate timing
`timescale 1ns/1ps
module drive_end #(
    parameter int REV_FAST = df_pkg::REV_FAST_CYC,
    parameter int REV_SLOW = df_pkg::REV_SLOW_CYC
) (
    input wire logic core_clk, // 10 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic ce, // clock enable
    df_link_if.drive link, // link pins
    input wire logic rpm_slow, // 1500 rpm variant
    input wire logic media_bit, // next bit under the head
    output logic media_take, // pulse: media_bit taken
    output logic flux_flip, // pulse: one flux reversal
    output logic flux_level, // current write current direction
    output logic [4:0] sector_num // sector under the head
);

    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic wp_s1_reg, wp_s2_reg, wp_s3_reg, wg_s1_reg, wg_s2_reg;
    logic rg_s1_reg, rg_s2_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {wp_s1_reg, wp_s2_reg, wp_s3_reg} <= 3'h0;
            {wg_s1_reg, wg_s2_reg, rg_s1_reg, rg_s2_reg} <= 4'h0;
        end else if (ce) begin
            {wp_s1_reg, wp_s2_reg, wp_s3_reg} <=
                {link.wr_pulse, wp_s1_reg, wp_s2_reg};
            {wg_s1_reg, wg_s2_reg} <= {link.write_gate, wg_s1_reg};
            {rg_s1_reg, rg_s2_reg} <= {link.read_gate, rg_s1_reg};
        end
    end

    // ---------------------------------------------------------------
    // marks, write flux, read cells
    // ---------------------------------------------------------------
    logic [19:0] slot_reg, slot_next, slot_len;
    logic [4:0] sect_reg, sect_next;
    logic [2:0] ph_reg, ph_next;
    logic bit_reg, bit_next, smark_reg, smark_next, imark_reg, imark_next;
    logic flux_reg, flux_next, flip_reg, flip_next, take_reg, take_next;
    logic rclk_reg, rclk_next, rdat_reg, rdat_next;

    always_comb begin
        slot_len = rpm_slow ? 20'(REV_SLOW / df_pkg::SECTORS)
                            : 20'(REV_FAST / df_pkg::SECTORS);
        slot_next = slot_reg + 20'h00001;
        sect_next = sect_reg;
        if (slot_reg >= slot_len - 20'h00001) begin
            slot_next = 20'h00000;
            sect_next = (sect_reg == 5'(df_pkg::SECTORS - 1)) ? 5'h00
                                                : sect_reg + 5'h01;
        end
        smark_next = !(slot_next < 20'(df_pkg::MARK_CYC));
        imark_next = !(slot_next < 20'(df_pkg::MARK_CYC)
                       && sect_next == 5'h00);
        flip_next = wp_s2_reg && !wp_s3_reg && wg_s2_reg;
        flux_next = flux_reg ^ flip_next;
        ph_next = 3'h0;
        bit_next = bit_reg;
        take_next = 1'b0;
        rclk_next = 1'b0;
        rdat_next = 1'b0;
        if (rg_s2_reg) begin
            ph_next = (ph_reg == 3'(df_pkg::CELL_CYC - 1)) ? 3'h0
                                                           : ph_reg + 3'h1;
            if (ph_reg == 3'h0) begin
                rclk_next = 1'b1;
                bit_next = media_bit;
                take_next = 1'b1;
            end
            if (ph_reg == 3'(df_pkg::CELL_CYC / 2)) begin
                rdat_next = bit_reg;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // start past the mark window so the first mark is full length
            slot_reg <= 20'(df_pkg::MARK_CYC);
            sect_reg <= 5'h00;
            ph_reg <= 3'h0;
            {bit_reg, flux_reg, flip_reg, take_reg} <= 4'h0;
            {rclk_reg, rdat_reg} <= 2'h0;
            {smark_reg, imark_reg} <= 2'h3;
        end else if (ce) begin
            slot_reg <= slot_next;
            sect_reg <= sect_next;
            ph_reg <= ph_next;
            {bit_reg, flux_reg, flip_reg, take_reg} <=
                {bit_next, flux_next, flip_next, take_next};
            {rclk_reg, rdat_reg} <= {rclk_next, rdat_next};
            {smark_reg, imark_reg} <= {smark_next, imark_next};
        end
    end

    assign link.read_clock = rclk_reg;
    assign link.read_data = rdat_reg;
    assign link.sector_mark_n = smark_reg;
    assign link.index_mark_n = imark_reg;
    assign media_take = take_reg;
    assign flux_flip = flip_reg;
    assign flux_level = flux_reg;
    assign sector_num = sect_reg;

endmodule

// ### hdl/controller_end.sv
// controller end: sector formatter, encoder and decoder, write FIFO
// assumes the drive answers on the link pins in the same clock rate
`timescale 1ns/1ps
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic core_clk, // clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic [W-1:0] in_data, // write data
    input wire logic in_valid, // write request
    output logic in_ready, // room left
    output logic [W-1:0] out_data, // head word
    output logic out_valid, // head word present
    input wire logic out_ready // head word taken
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic rdy_reg, push, pop;

    always_comb begin
        push = in_valid && rdy_reg;
        pop = out_ready && cnt_reg != '0;
        wp_next = wp_reg;
        rp_next = rp_reg;
        if (push) wp_next = (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
        if (pop) rp_next = (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b0;
        end else if (ce) begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            rdy_reg <= cnt_next < (AW+1)'(D);
            if (push) mem_reg[wp_reg] <= in_data;
        end
    end

    assign in_ready = rdy_reg;
    assign out_data = mem_reg[rp_reg];
    assign out_valid = cnt_reg != '0;
endmodule

// Functional notes
// - every bit cell opens with clock pulse
// - one bit adds mid-cell data pulse
// - every pulse lasts nominally 100 ns
// - clock and data share one write line
// - drive flips flux once per pulse
// - drive returns clock and data separately
// - revolution 25 ms, 40 ms slow variant
// - equal sectors, revolution over sector count
// - preamble and postamble hold clock pulses only
// - data field length fixed, guards absorb
// - sync, header, check, gap, sync, data, check
// - preamble bytes are hex zero
// - write gate one byte after header check
// - read gate at preamble midpoint
// - field byte counts and byte time
// - usable sector time from formula
// - data bytes fit usable time less tolerances
// - sync is two bytes hex 03
// - gates drop at next sector mark; read gate drops after the header or data check bytes instead
// - drive sector mark active low 40 us
module controller_end (
    input wire logic core_clk, // 10 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic ce, // clock enable
    df_link_if.ctrl link, // link pins
    input wire logic start, // pulse: begin operation at next mark
    input wire df_pkg::op_t op, // format, write data or read
    input wire logic long_pre, // 16 byte preamble
    input wire logic [15:0] hdr_in, // header to format
    input wire logic [7:0] wr_byte, // data byte to write
    input wire logic wr_valid, // data byte offered
    output logic wr_ready, // FIFO has room
    output logic [7:0] rd_byte, // data byte read
    output logic rd_valid, // pulse: rd_byte valid
    output logic [15:0] hdr_out, // header read
    output logic busy, // operation running
    output logic done, // pulse: operation ended
    output logic hdr_err, // header check mismatch
    output logic data_err, // data check mismatch
    output logic underrun // FIFO empty during data field
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT, ST_PRE, ST_SYNC1, ST_HDR, ST_HCHK, ST_GAP,
        ST_SYNC2, ST_DATA, ST_DCHK, ST_POST, ST_RD_HALF, ST_RD_HDR,
        ST_WDLY, ST_RD_GAP, ST_RD_DATA
    } st_t;

    // ---------------------------------------------------------------
    // synchronisers and write FIFO
    // ---------------------------------------------------------------
    logic sm_s1_reg, sm_s2_reg, sm_s3_reg, rc_s1_reg, rc_s2_reg, rc_s3_reg;
    logic rd_s1_reg, rd_s2_reg, rd_s3_reg, lead, fifo_pop, fifo_valid;
    logic [7:0] fifo_data;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {sm_s1_reg, sm_s2_reg, sm_s3_reg} <= 3'h7;
            {rc_s1_reg, rc_s2_reg, rc_s3_reg} <= 3'h0;
            {rd_s1_reg, rd_s2_reg, rd_s3_reg} <= 3'h0;
        end else if (ce) begin
            {sm_s1_reg, sm_s2_reg, sm_s3_reg} <=
                {link.sector_mark_n, sm_s1_reg, sm_s2_reg};
            {rc_s1_reg, rc_s2_reg, rc_s3_reg} <=
                {link.read_clock, rc_s1_reg, rc_s2_reg};
            {rd_s1_reg, rd_s2_reg, rd_s3_reg} <=
                {link.read_data, rd_s1_reg, rd_s2_reg};
        end
    end

    assign lead = sm_s3_reg && !sm_s2_reg;

    byte_fifo #(.W(df_pkg::FIFO_W), .D(df_pkg::FIFO_D)) u_fifo (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .in_data(wr_byte), .in_valid(wr_valid), .in_ready(wr_ready),
        .out_data(fifo_data), .out_valid(fifo_valid), .out_ready(fifo_pop)
    );

    // ---------------------------------------------------------------
    // read decoder
    // ---------------------------------------------------------------
    logic rg_reg, open_reg, open_next, one_reg, one_next, fr_reg, fr_next;
    logic stb_reg, stb_next, nbit;
    logic [15:0] sh_reg, sh_next;
    logic [2:0] bc_reg, bc_next;
    logic [7:0] rx_reg, rx_next;

    always_comb begin
        {open_next, one_next, fr_next} = {open_reg, one_reg, fr_reg};
        {sh_next, bc_next, rx_next, stb_next} = {sh_reg, bc_reg, rx_reg, 1'b0};
        nbit = one_reg;
        if (!rg_reg) begin
            {open_next, one_next, fr_next} = 3'h0;
        end else begin
            if (rd_s2_reg && !rd_s3_reg) one_next = 1'b1;
            if (rc_s2_reg && !rc_s3_reg) begin
                open_next = 1'b1;
                one_next = 1'b0;
                if (open_reg) begin
                    sh_next = {sh_reg[14:0], nbit};
                    if (fr_reg) begin
                        bc_next = bc_reg + 3'h1;
                        if (bc_reg == 3'h7) begin
                            stb_next = 1'b1;
                            rx_next = {sh_reg[6:0], nbit};
                        end
                    end else if ({sh_reg[14:0], nbit} == df_pkg::SYNC_WORD) begin
                        fr_next = 1'b1;
                        bc_next = 3'h0;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {open_reg, one_reg, fr_reg, stb_reg} <= 4'h0;
            sh_reg <= 16'h0000;
            bc_reg <= 3'h0;
            rx_reg <= 8'h00;
        end else if (ce) begin
            {open_reg, one_reg, fr_reg, stb_reg} <=
                {open_next, one_next, fr_next, stb_next};
            sh_reg <= sh_next;
            bc_reg <= bc_next;
            rx_reg <= rx_next;
        end
    end

    // ---------------------------------------------------------------
    // sector sequencer and encoder
    // ---------------------------------------------------------------
    st_t st_reg, st_next;
    df_pkg::op_t op_reg, op_next;
    logic [15:0] cnt_reg, cnt_next, chk_reg, chk_next, len;
    logic [15:0] hdr_reg, hdr_next, hout_reg, hout_next;
    logic [4:0] cyc_reg, cyc_next;
    logic [7:0] tx, rdb_reg, rdb_next;
    logic [2:0] bi;
    logic lp_reg, lp_next, wg_reg, wg_next, rg_next, wp_reg, wp_next;
    logic busy_reg, busy_next, done_reg, done_next, rdv_reg, rdv_next;
    logic he_reg, he_next, de_reg, de_next, ur_reg, ur_next, bend, last;

    always_comb begin
        st_next = st_reg;
        {op_next, hdr_next, hout_next, lp_next} = {op_reg, hdr_reg, hout_reg,
                                                    lp_reg};
        {cnt_next, chk_next, rdb_next} = {cnt_reg, chk_reg, rdb_reg};
        {wg_next, rg_next, busy_next} = {wg_reg, rg_reg, busy_reg};
        {he_next, de_next, ur_next} = {he_reg, de_reg, ur_reg};
        {done_next, rdv_next, fifo_pop} = 3'h0;
        cyc_next = cyc_reg + 5'h01;
        bend = cyc_reg == 5'(df_pkg::BYTE_CYC - 1);
        case (st_reg)
            ST_PRE: len = lp_reg ? 16'(df_pkg::PRE_LONG_BYTES)
                                 : 16'(df_pkg::PRE_BYTES);
            ST_SYNC1, ST_SYNC2: len = 16'(df_pkg::SYNC_BYTES);
            ST_HDR: len = 16'(df_pkg::HDR_BYTES);
            ST_GAP: len = 16'(df_pkg::GAP_BYTES);
            ST_DATA: len = 16'(df_pkg::DATA_BYTES);
            ST_RD_HALF: len = (lp_reg ? 16'(df_pkg::PRE_LONG_BYTES)
                                      : 16'(df_pkg::PRE_BYTES)) >> 1;
            default: len = 16'(df_pkg::CHK_BYTES);
        endcase
        last = cnt_reg == len - 16'h0001;
        case (st_reg)
            ST_SYNC1, ST_SYNC2: tx = df_pkg::SYNC_BYTE;
            ST_HDR: tx = cnt_reg[0] ? hdr_reg[7:0] : hdr_reg[15:8];
            ST_HCHK, ST_DCHK: tx = cnt_reg[0] ? chk_reg[7:0] : chk_reg[15:8];
            ST_DATA: tx = fifo_valid ? fifo_data : df_pkg::ZERO_BYTE;
            default: tx = df_pkg::ZERO_BYTE;
        endcase
        bi = 3'(int'(cyc_reg) / df_pkg::CELL_CYC);
        wp_next = wg_reg && (int'(cyc_reg) % df_pkg::CELL_CYC == 0
            || (int'(cyc_reg) % df_pkg::CELL_CYC == df_pkg::CELL_CYC / 2
                && tx[3'h7 - bi]));
        case (st_reg)
            ST_IDLE: begin
                cyc_next = 5'h00;
                if (start) begin
                    {op_next, hdr_next, lp_next} = {op, hdr_in, long_pre};
                    {he_next, de_next, ur_next} = 3'h0;
                    busy_next = 1'b1;
                    st_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                cyc_next = 5'h00;
                cnt_next = 16'h0000;
                if (lead) begin
                    if (op_reg == df_pkg::OP_FORMAT) begin
                        wg_next = 1'b1;
                        st_next = ST_PRE;
                    end else begin
                        st_next = ST_RD_HALF;
                    end
                end
            end
            ST_RD_HALF: if (bend) begin
                cnt_next = cnt_reg + 16'h0001;
                if (last) begin
                    rg_next = 1'b1;
                    cnt_next = 16'h0000;
                    chk_next = 16'h0000;
                    st_next = ST_RD_HDR;
                end
            end
            ST_RD_HDR, ST_RD_DATA: if (stb_reg) begin
                cnt_next = cnt_reg + 16'h0001;
                if (st_reg == ST_RD_HDR && cnt_reg < 16'h0002) begin
                    hout_next = {hout_reg[7:0], rx_reg};
                    chk_next = chk_reg + 16'(rx_reg);
                end else if (st_reg == ST_RD_DATA
                             && cnt_reg < 16'(df_pkg::DATA_BYTES)) begin
                    {rdb_next, rdv_next} = {rx_reg, 1'b1};
                    chk_next = chk_reg + 16'(rx_reg);
                end else if (rx_reg != (cnt_reg[0] ? chk_reg[7:0]
                                                   : chk_reg[15:8])) begin
                    he_next = he_reg || st_reg == ST_RD_HDR;
                    de_next = de_reg || st_reg == ST_RD_DATA;
                end
                if (st_reg == ST_RD_HDR && cnt_reg == 16'h0003) begin
                    rg_next = 1'b0;
                    cnt_next = 16'h0000;
                    cyc_next = 5'h00;
                    st_next = op_reg == df_pkg::OP_WRITE ? ST_WDLY : ST_RD_GAP;
                end
                if (st_reg == ST_RD_DATA && cnt_reg ==
                        16'(df_pkg::DATA_BYTES + df_pkg::CHK_BYTES - 1)) begin
                    {rg_next, busy_next, done_next} = 3'b001;
                    st_next = ST_IDLE;
                end
            end
            ST_WDLY: if (bend) begin
                wg_next = 1'b1;
                st_next = ST_GAP;
            end
            ST_RD_GAP: if (cyc_reg == 5'(df_pkg::BYTE_CYC
                                         * df_pkg::GAP_BYTES / 2 - 1)) begin
                rg_next = 1'b1;
                chk_next = 16'h0000;
                st_next = ST_RD_DATA;
            end
            ST_POST: ;
            default: if (bend) begin
                cnt_next = last ? 16'h0000 : cnt_reg + 16'h0001;
                if (st_reg == ST_HDR || st_reg == ST_DATA)
                    chk_next = chk_reg + 16'(tx);
                if (st_reg == ST_SYNC1 || st_reg == ST_SYNC2)
                    chk_next = 16'h0000;
                if (st_reg == ST_DATA) begin
                    fifo_pop = fifo_valid;
                    ur_next = ur_reg || !fifo_valid;
                end
                if (last) st_next = st_t'(st_reg + 4'h1);
            end
        endcase
        if (wg_reg && lead) begin
            {wg_next, busy_next, done_next} = 3'b001;
            // no pulse may leave on the edge that drops the gate
            wp_next = 1'b0;
            st_next = ST_IDLE;
        end
        if (st_reg == ST_RD_HDR || st_reg == ST_RD_DATA) begin
            if (!fr_reg) cnt_next = 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_reg <= ST_IDLE;
            op_reg <= df_pkg::OP_FORMAT;
            {cnt_reg, chk_reg, hdr_reg, hout_reg} <= 64'h0;
            cyc_reg <= 5'h00;
            rdb_reg <= 8'h00;
            {lp_reg, wg_reg, rg_reg, wp_reg, busy_reg} <= 5'h00;
            {done_reg, rdv_reg, he_reg, de_reg, ur_reg} <= 5'h00;
        end else if (ce) begin
            st_reg <= st_next;
            op_reg <= op_next;
            {cnt_reg, chk_reg, hdr_reg, hout_reg} <=
                {cnt_next, chk_next, hdr_next, hout_next};
            cyc_reg <= cyc_next;
            rdb_reg <= rdb_next;
            {lp_reg, wg_reg, rg_reg, wp_reg, busy_reg} <=
                {lp_next, wg_next, rg_next, wp_next, busy_next};
            {done_reg, rdv_reg, he_reg, de_reg, ur_reg} <=
                {done_next, rdv_next, he_next, de_next, ur_next};
        end
    end

    assign link.wr_pulse = wp_reg;
    assign link.write_gate = wg_reg;
    assign link.erase_gate = wg_reg;
    assign link.read_gate = rg_reg;
    assign {rd_byte, rd_valid, hdr_out} = {rdb_reg, rdv_reg, hout_reg};
    assign {busy, done, hdr_err, data_err, underrun} =
        {busy_reg, done_reg, he_reg, de_reg, ur_reg};

endmodule

// ### test/df_link_monitor.sv
// assertions on the link pins between the two ends
// assumes both ends share core_clk and rst_b
`timescale 1ns/1ps
module df_link_monitor (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic wr_pulse, // write pulses
    input wire logic write_gate, // write gate
    input wire logic erase_gate, // erase gate
    input wire logic read_clock, // read clock
    input wire logic read_data, // read data
    input wire logic sector_mark_n // sector mark
);
    int low_reg;
    int low_next;
    always_comb begin
        low_next = sector_mark_n ? 0 : low_reg + 1;
    end
    always_ff @(posedge core_clk) begin
        low_reg <= rst_b ? low_next : 0;
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    gate_pair_a: assert property (erase_gate == write_gate)
        else $error("erase gate differs from write gate");
    write_width_a: assert property (wr_pulse |=> !wr_pulse)
        else $error("write pulse too wide");
    write_gated_a: assert property (wr_pulse |-> write_gate)
        else $error("write pulse outside write gate");
    cell_open_a: assert property ($rose(write_gate) |=> wr_pulse)
        else $error("no clock pulse after write gate");
    clock_space_a: assert property (read_clock |=> !read_clock [*3])
        else $error("read clock closer than one cell");
    data_phase_a: assert property (read_data |-> $past(read_clock, 2))
        else $error("read data not at mid cell");
    split_lines_a: assert property (!(read_clock && read_data))
        else $error("read clock and data together");
    data_width_a: assert property (read_data |=> !read_data)
        else $error("read data pulse too wide");
    mark_len_a: assert property ($rose(sector_mark_n) |->
        low_reg == df_pkg::MARK_CYC)
        else $error("sector mark length wrong");
endmodule

// ### test/double_frequency_sector_formatter_bench.sv
// bench: controller and drive joined by the link interface
// assumes a shortened revolution, 5000 cycle sector slots
`timescale 1ns/1ps
module double_frequency_sector_formatter_bench;
    logic core_clk = 0;
    logic rst_b = 0;
    logic start = 0;
    df_pkg::op_t op = df_pkg::OP_FORMAT;
    logic [7:0] wr_byte = 8'hA5;
    logic wr_valid = 0;
    logic media_bit = 0;
    logic ce = 1;
    logic long_pre = 0;
    logic wr_ready, busy, done, underrun, media_take, flux_flip;
    int err_count = 0;
    int check_count = 0;
    int n, m;
    df_link_if link();
    controller_end u_controller_end (.core_clk, .rst_b, .ce, .link,
        .start, .op, .long_pre, .hdr_in(16'h1234), .wr_byte,
        .wr_valid, .wr_ready, .rd_byte(), .rd_valid(), .hdr_out(), .busy,
        .done, .hdr_err(), .data_err(), .underrun);
    drive_end #(.REV_FAST(40000), .REV_SLOW(64000)) u_drive_end (.core_clk,
        .rst_b, .ce, .link, .rpm_slow(1'b0), .media_bit, .media_take,
        .flux_flip, .flux_level(), .sector_num());
    df_link_monitor u_df_link_monitor (.core_clk, .rst_b,
        .wr_pulse(link.wr_pulse), .write_gate(link.write_gate),
        .erase_gate(link.erase_gate), .read_clock(link.read_clock),
        .read_data(link.read_data), .sector_mark_n(link.sector_mark_n));
    initial forever #50 core_clk = ~core_clk;
    // media alternates 0101 so every other cell carries a one
    always @(posedge core_clk) if (media_take) media_bit <= ~media_bit;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic await(int sel, int lim);
        for (int i = 0; i <= lim; i++) begin
            @(negedge core_clk);
            if (sel == 0 ? done : sel == 1 ? link.write_gate : link.read_gate)
                return;
        end
        err_count++;
        complete_run();
    endtask
    task automatic go(df_pkg::op_t o);
        @(posedge core_clk);
        op <= o;
        long_pre <= (o == df_pkg::OP_READ);
        start <= 1;
        @(posedge core_clk);
        start <= 0;
    endtask
    task automatic t_fifo();
        n = 0;
        ce <= 0;
        wr_valid <= 1;
        repeat (4) @(negedge core_clk);
        check("ready while frozen", 16'h0000, 16'(wr_ready));
        @(posedge core_clk);
        ce <= 1;
        for (int i = 0; i < 20; i++) begin
            @(negedge core_clk);
            if (wr_ready) n++;
            else if (n > 0) break;
        end
        @(posedge core_clk);
        wr_valid <= 0;
        check("fifo depth", 16'(df_pkg::FIFO_D), 16'(n));
    endtask
    task automatic t_format();
        int p = 0;
        int f = 0;
        go(df_pkg::OP_FORMAT);
        await(1, 12000);
        n = 0;
        for (int i = 0; i < 12000 && done !== 1'b1; i++) begin
            @(negedge core_clk);
            if (i < 256) n += link.wr_pulse;
            p += link.wr_pulse;
            f += flux_flip;
        end
        repeat (8) @(negedge core_clk) f += flux_flip;
        check("preamble and sync pulses", 16'h0044, 16'(n));
        check("flux flips", 16'(p), 16'(f));
        check("write gate after done", 16'h0000, 16'(link.write_gate));
        check("underrun", 16'h0001, 16'(underrun));
    endtask
    task automatic t_read();
        // four cycles of sync and edge detect ahead of half the preamble
        int exp_rg = 4 + df_pkg::PRE_LONG_BYTES / 2 * df_pkg::BYTE_CYC;
        go(df_pkg::OP_READ);
        n = 0;
        for (int i = 0; i < 12000 && link.read_gate !== 1'b1; i++) begin
            @(negedge core_clk);
            n = link.sector_mark_n ? 0 : n + 1;
        end
        check("read gate delay", 16'(exp_rg), 16'(n));
        await(2, 12000);
        repeat (8) @(negedge core_clk);
        n = 0;
        m = 0;
        repeat (256) begin
            @(negedge core_clk);
            n += link.read_clock;
            m += link.read_data;
        end
        check("read clocks", 16'h0040, 16'(n));
        check("read data", 16'h0020, 16'(m));
        @(posedge core_clk);
        rst_b <= 0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1;
        @(negedge core_clk);
        check("busy after abort", 16'h0000, 16'(busy));
        check("read gate after abort", 16'h0000, 16'(link.read_gate));
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1;
        t_fifo();
        t_format();
        t_read();
        complete_run();
    end
endmodule
